// file: sar_adc_control_defines.svh
// Register indices, field positions, reset values and timing counts of the converter control block
`ifndef SAR_ADC_CONTROL_DEFINES_SVH
`define SAR_ADC_CONTROL_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_IRQ_ENABLE 6'h00
`define IDX_IRQ_REQUEST 6'h01
`define IDX_CHANNEL_REFERENCE_CONFIG 6'h07
`define IDX_PIN_ANALOG_SELECT 6'h08
`define IDX_CONVERSION_CONTROL 6'h09
`define IDX_RESULT_LOW_NIBBLE 6'h0A
`define IDX_RESULT_MID_NIBBLE 6'h0B
`define IDX_RESULT_HIGH_NIBBLE 6'h0C

// Field positions
`define CFG_MODULE_ENABLE 0
`define CFG_CHANNEL_LSB 1
`define CFG_CHANNEL_MSB 2
`define CFG_REFERENCE_SOURCE 3
`define CTL_LENGTH_SELECT 0
`define CTL_DIV_LSB 1
`define CTL_DIV_MSB 2
`define CTL_START_DONE 3
`define IRQ_CONVERTER_BIT 3

// Reset values
`define RST_NIBBLE 4'h0
`define RST_RESULT 10'h000

// Conversion lengths in converter clock periods
`define LEN_SHORT 7'd15
`define LEN_LONG 7'd114
`define TRIAL_BITS 7'd10

// Timing: oscillator period, system period and end-to-acquisition gap
`define CLK_PS 25000
`define TOSC_PS 62500
`define TSYS_TOSC 16
`define GAP_TOSC 16
`define TSYS_CYC ((`TSYS_TOSC * `TOSC_PS + `CLK_PS - 1) / `CLK_PS)
`define GAP_CYC ((`GAP_TOSC * `TOSC_PS + `CLK_PS - 1) / `CLK_PS)

`endif

// file: sar_adc_control_pkg.sv
// Types shared by the converter control block
`default_nettype none
package sar_adc_control_pkg;

	typedef enum logic [1:0] {
		S_IDLE,
		S_HOLD,
		S_ACQ,
		S_TRIAL
	} conv_state_e;

	typedef struct packed {
		conv_state_e st;
		logic [3:0] cfg;
		logic [3:0] pins;
		logic [3:0] ctrl;
		logic [9:0] res;
		logic [9:0] sar;
		logic [3:0] bidx;
		logic ien;
		logic ireq;
		logic [5:0] pre;
		logic [2:0] dcnt;
		logic [6:0] tcnt;
		logic [5:0] gcnt;
		logic ack;
		logic [3:0] rdat;
		logic irq;
		logic wake;
		logic samp;
		logic pwr;
	} ctl_state_s;

endpackage
`default_nettype wire

// file: sar_adc_control.sv
// Control logic of a four-channel 10-bit successive-approximation converter with a Wishbone slave
// Operation
// R1: Enable bit powers and permits converter
// R2: Channel field routes one of four inputs
// R3: Reference bit picks supply or external pin
// R4: Pin select bits make pins analog inputs
// R5: Analog pins lose digital function, pull-high
// R6: Length bit gives 15 or 114 periods
// R7: Divider gives 1, 2, 4, 8 system periods
// R8: Writing start begins; bit holds while busy
// R9: Hardware clears start bit on completion
// R10: Writing zero while busy aborts conversion
// R11: Aborted conversion leaves result untouched
// R12: Result split over three read-only nibbles
// R13: Completion raises request; enable gates interrupt
// R14: Sixteen oscillator periods before next acquisition
// R15: Runs in halt, stops on stop
// R16: Enabled completion wakes core from halt
// R17: Software keeps converter period within limits
// R18: Software sets analog pins as inputs
// R19: Software configures before setting start
// R20: Enable and request sit at bit three
// R21: Start ignored while module is disabled
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_control_defines.svh"

module sar_adc_control
	import sar_adc_control_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic WB_ACK_O,
	output logic [31:0] WB_DAT_O,
	input wire logic COMP_I,
	input wire logic HALT_I,
	input wire logic STOP_I,
	output logic ADC_PWR_O,
	output logic SAMPLE_O,
	output logic [1:0] CH_SEL_O,
	output logic VREF_EXT_O,
	output logic [9:0] DAC_CODE_O,
	output logic [3:0] ANALOG_SEL_O,
	output logic IRQ_O,
	output logic WAKE_O
);

	localparam ctl_state_s RST = '{
		st: S_IDLE,
		cfg: `RST_NIBBLE,
		pins: `RST_NIBBLE,
		ctrl: `RST_NIBBLE,
		res: `RST_RESULT,
		sar: `RST_RESULT,
		bidx: 4'h0,
		ien: 1'b0,
		ireq: 1'b0,
		pre: 6'h00,
		dcnt: 3'h0,
		tcnt: 7'h00,
		gcnt: 6'h00,
		ack: 1'b0,
		rdat: 4'h0,
		irq: 1'b0,
		wake: 1'b0,
		samp: 1'b0,
		pwr: 1'b0
	};
	localparam logic [5:0] TSYS_LAST = 6'(`TSYS_CYC - 1);
	localparam logic [5:0] GAP_LOAD = 6'(`GAP_CYC);

	ctl_state_s q;
	ctl_state_s next_q;
	logic acc;
	logic wr;
	logic sys_tick;
	logic tad_tick;
	logic fin;
	logic kill;
	logic [5:0] idx;
	logic [6:0] len;

	// Last divider count for each setting
	function automatic logic [2:0] div_last(input logic [1:0] d);
		case (d)
			2'h0: div_last = 3'h0;
			2'h1: div_last = 3'h1;
			2'h2: div_last = 3'h3;
			default: div_last = 3'h7;
		endcase
	endfunction

	function automatic logic [6:0] conv_len(input logic long_sel);
		conv_len = long_sel ? `LEN_LONG : `LEN_SHORT;
	endfunction

	always_comb begin
		next_q = q;
		idx = WB_ADR_I[7:2];
		acc = WB_CYC_I & WB_STB_I & ~q.ack;
		wr = acc & WB_WE_I & WB_SEL_I[0];
		sys_tick = 1'b0;
		tad_tick = 1'b0;
		fin = 1'b0;
		// R15: stop halts the converter, halt does not
		kill = STOP_I | ~q.cfg[`CFG_MODULE_ENABLE];
		len = conv_len(q.ctrl[`CTL_LENGTH_SELECT]);
		next_q.ack = acc;
		if (q.gcnt != 6'h00) begin
			next_q.gcnt = q.gcnt - 6'h01;
		end
		// R7: system period then converter period divider
		if (q.st == S_ACQ || q.st == S_TRIAL) begin
			if (q.pre == TSYS_LAST) begin
				next_q.pre = 6'h00;
				sys_tick = 1'b1;
			end else begin
				next_q.pre = q.pre + 6'h01;
			end
			if (sys_tick) begin
				if (q.dcnt >= div_last(q.ctrl[`CTL_DIV_MSB:`CTL_DIV_LSB])) begin
					next_q.dcnt = 3'h0;
					tad_tick = 1'b1;
				end else begin
					next_q.dcnt = q.dcnt + 3'h1;
				end
			end
		end
		case (q.st)
			S_IDLE: begin
			end
			// R14: acquisition waits out the gap
			S_HOLD: begin
				if (q.gcnt == 6'h00) begin
					next_q.st = S_ACQ;
				end
			end
			// R6: acquisition fills all but ten periods
			S_ACQ: begin
				if (tad_tick) begin
					next_q.tcnt = q.tcnt + 7'h01;
					if (q.tcnt == len - `TRIAL_BITS - 7'h01) begin
						next_q.st = S_TRIAL;
						next_q.sar = 10'h200;
						next_q.bidx = 4'h9;
					end
				end
			end
			S_TRIAL: begin
				if (tad_tick) begin
					next_q.tcnt = q.tcnt + 7'h01;
					if (!COMP_I) begin
						next_q.sar[q.bidx] = 1'b0;
					end
					if (q.bidx == 4'h0) begin
						fin = 1'b1;
					end else begin
						next_q.sar[q.bidx - 4'h1] = 1'b1;
						next_q.bidx = q.bidx - 4'h1;
					end
				end
			end
			default: begin
				next_q.st = S_IDLE;
			end
		endcase
		// R9 R11 R13: completion clears start, raises request and is the only load of result
		if (fin) begin
			next_q.res = next_q.sar;
			next_q.ctrl[`CTL_START_DONE] = 1'b0;
			next_q.ireq = 1'b1;
			next_q.st = S_IDLE;
			next_q.gcnt = GAP_LOAD;
		end
		if (wr) begin
			case (idx)
				// R20: converter flags at bit three
				`IDX_IRQ_ENABLE: next_q.ien = WB_DAT_I[`IRQ_CONVERTER_BIT];
				`IDX_IRQ_REQUEST: next_q.ireq = WB_DAT_I[`IRQ_CONVERTER_BIT] | fin;
				`IDX_CHANNEL_REFERENCE_CONFIG: next_q.cfg = WB_DAT_I[3:0];
				`IDX_PIN_ANALOG_SELECT: next_q.pins = WB_DAT_I[3:0];
				`IDX_CONVERSION_CONTROL: begin
					next_q.ctrl[2:0] = WB_DAT_I[2:0];
					if (WB_DAT_I[`CTL_START_DONE]) begin
						// R8 R21: start only when idle and enabled
						if (q.st == S_IDLE && !fin && !kill) begin
							next_q.ctrl[`CTL_START_DONE] = 1'b1;
							next_q.st = (q.gcnt == 6'h00) ? S_ACQ : S_HOLD;
							next_q.pre = 6'h00;
							next_q.dcnt = 3'h0;
							next_q.tcnt = 7'h00;
							next_q.sar = 10'h000;
						end
					end else if (!fin) begin
						// R10: abort, result kept
						next_q.ctrl[`CTL_START_DONE] = 1'b0;
						next_q.st = S_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
		// R1 R15: disable or stop ends any conversion
		if (kill && !fin) begin
			next_q.ctrl[`CTL_START_DONE] = 1'b0;
			next_q.st = S_IDLE;
		end
		if (acc && !WB_WE_I) begin
			case (idx)
				`IDX_IRQ_ENABLE: next_q.rdat = {q.ien, 3'h0};
				`IDX_IRQ_REQUEST: next_q.rdat = {q.ireq, 3'h0};
				`IDX_CHANNEL_REFERENCE_CONFIG: next_q.rdat = q.cfg;
				`IDX_PIN_ANALOG_SELECT: next_q.rdat = q.pins;
				`IDX_CONVERSION_CONTROL: next_q.rdat = q.ctrl;
				// R12: result nibble packing
				`IDX_RESULT_LOW_NIBBLE: next_q.rdat = {q.res[2:0], 1'b0};
				`IDX_RESULT_MID_NIBBLE: next_q.rdat = q.res[6:3];
				`IDX_RESULT_HIGH_NIBBLE: next_q.rdat = {1'b0, q.res[9:7]};
				default: next_q.rdat = 4'h0;
			endcase
		end
		// R13 R16: request gated by enable, wake only in halt
		next_q.irq = next_q.ireq & next_q.ien;
		next_q.wake = next_q.ireq & next_q.ien & HALT_I;
		next_q.samp = (next_q.st == S_ACQ);
		next_q.pwr = next_q.cfg[`CFG_MODULE_ENABLE] & ~STOP_I;
	end

	always_ff @(posedge CLK_I) begin
		if (!RESETN_I) begin
			q <= RST;
		end else begin
			q <= next_q;
		end
	end

	assign WB_ACK_O = q.ack;
	assign WB_DAT_O = {28'h0000000, q.rdat};
	assign IRQ_O = q.irq;
	assign WAKE_O = q.wake;
	assign SAMPLE_O = q.samp;
	// R1: module power follows enable
	assign ADC_PWR_O = q.pwr;
	// R2 R3: channel and reference routing
	assign CH_SEL_O = q.cfg[`CFG_CHANNEL_MSB:`CFG_CHANNEL_LSB];
	assign VREF_EXT_O = q.cfg[`CFG_REFERENCE_SOURCE];
	// R4 R5: a set bit disables digital buffer and pull-high
	assign ANALOG_SEL_O = q.pins;
	assign DAC_CODE_O = q.sar;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	logic go;
	assign go = q.ctrl[`CTL_START_DONE];

	sequence s_finish;
		fin;
	endsequence

	sequence s_no_acq8;
		(q.st != S_ACQ)[*8];
	endsequence

	a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O) // Wishbone handshake
		else $error("ack held over two cycles");
	a_disable_kills: assert property ($fell(q.cfg[`CFG_MODULE_ENABLE]) |=> !go && q.st == S_IDLE) // R1
		else $error("conversion survives disable");
	a_start_needs_en: assert property (go |-> q.cfg[`CFG_MODULE_ENABLE] || $fell(q.cfg[`CFG_MODULE_ENABLE])) // R21
		else $error("start bit set while disabled");
	a_res_only_done: assert property (q.res != $past(q.res) |-> $past(fin)) // R11
		else $error("result changed without completion");
	a_done_clears: assert property (s_finish |=> !go && q.st == S_IDLE) // R9
		else $error("start bit not cleared at completion");
	a_done_irq: assert property (s_finish |=> q.ireq ##1 (IRQ_O == q.ien)) // R13
		else $error("request not raised at completion");
	a_abort_now: assert property ((wr && idx == `IDX_CONVERSION_CONTROL && !WB_DAT_I[3] && !fin)
		|=> !go && q.st == S_IDLE && $stable(q.res)) // R10
		else $error("abort not immediate");
	a_gap_hold: assert property (s_finish |=> s_no_acq8) // R14
		else $error("acquisition inside gap");
	a_conv_len: assert property (s_finish |-> q.tcnt == conv_len(q.ctrl[`CTL_LENGTH_SELECT]) - 7'h01) // R6
		else $error("wrong conversion length");
	a_stop_ends: assert property (STOP_I |=> !go && !ADC_PWR_O) // R15
		else $error("converter runs during stop");
	// A write in the same cycle may clear the request or enable first
	a_halt_wake: assert property ((HALT_I && q.ireq && q.ien && !wr) |=> WAKE_O) // R16
		else $error("no wake from halt");

endmodule
`default_nettype wire

// file: adc_comparator_model.sv
// Comparator model: four analog levels against the trial code
`timescale 1ns/1ps
`default_nettype none
module adc_comparator_model (
	input wire logic [39:0] level_i,
	input wire logic [1:0] ch_i,
	input wire logic [9:0] code_i,
	output logic comp_o
);
	// selected level against code
	// Ideal comparator, so the settled code equals the chosen level
	assign comp_o = level_i[ch_i * 10 +: 10] >= code_i;
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_control_defines.svh"
module tb;
	logic clk = 0;
	logic rstn = 0;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic halt = 0;
	logic stop = 0;
	logic comp, ack, pwr, samp, vext, irq, wake;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dout, rdat;
	logic [1:0] ch;
	logic [9:0] code;
	logic [3:0] asel, pins;
	logic [39:0] level = 40'h0;
	logic [9:0] res;
	logic [31:0] seed = 32'h00010F11;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	sar_adc_control uut (.CLK_I(clk), .RESETN_I(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_ACK_O(ack), .WB_DAT_O(dout), .COMP_I(comp),
		.HALT_I(halt), .STOP_I(stop), .ADC_PWR_O(pwr), .SAMPLE_O(samp), .CH_SEL_O(ch), .VREF_EXT_O(vext),
		.DAC_CODE_O(code), .ANALOG_SEL_O(asel), .IRQ_O(irq), .WAKE_O(wake));
	adc_comparator_model cmp (.level_i(level), .ch_i(ch), .code_i(code), .comp_o(comp));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] idx, input logic [3:0] d);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {28'h0, d};
		@(posedge clk);
		do @(posedge clk); while (ack !== 1'b1);
		rdat = dout;
		cyc <= 0;
		stb <= 0;
		@(posedge clk);
	endtask
	task automatic rdres();
		bus(0, `IDX_RESULT_LOW_NIBBLE, 4'h0);
		chk("low nibble", {res[2:0], 1'b0}, rdat);
		bus(0, `IDX_RESULT_MID_NIBBLE, 4'h0);
		chk("mid nibble", res[6:3], rdat);
		bus(0, `IDX_RESULT_HIGH_NIBBLE, 4'h0);
		chk("high nibble", res[9:7], rdat);
	endtask
	task automatic conv(input logic len, input logic [1:0] div, input logic [1:0] c, input logic ext);
		int t0, dur;
		// software waits out the gap so acquisition starts at once
		repeat (`GAP_CYC) @(posedge clk);
		for (int i = 0; i < 4; i++)
			level[i * 10 +: 10] <= 10'(xs());
		bus(1, `IDX_CHANNEL_REFERENCE_CONFIG, {ext, c, 1'b1});
		chk("channel", c, ch);
		chk("reference", ext, vext);
		chk("power", 1, pwr);
		t0 = cycles;
		bus(1, `IDX_CONVERSION_CONTROL, {1'b1, div, len});
		bus(0, `IDX_CONVERSION_CONTROL, 4'h0);
		chk("busy", 1, rdat[3]);
		chk("sampling", 1, samp);
		while (rdat[3] === 1'b1)
			bus(0, `IDX_CONVERSION_CONTROL, 4'h0);
		dur = cycles - t0;
		t0 = (len ? 114 : 15) * `TSYS_CYC << div;
		// The gap after the previous completion has run out before start, so start is not held
		chk("length", 1, dur >= t0 && dur <= t0 + `GAP_CYC + 12);
		res = level[c * 10 +: 10];
		chk("request", 1, irq);
		chk("wake", halt, wake);
		bus(1, `IDX_IRQ_REQUEST, 4'h0);
		chk("cleared", 0, irq);
		rdres();
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		for (int i = 7; i < 13; i++) begin
			bus(0, 6'(i), 4'h0);
			chk("reset value", 0, rdat);
		end
		bus(0, 6'h3F, 4'h0);
		chk("unmapped", 0, rdat);
		pins = 4'(xs());
		bus(1, `IDX_PIN_ANALOG_SELECT, pins);
		chk("pin roles", pins, asel);
		bus(0, `IDX_PIN_ANALOG_SELECT, 4'h0);
		chk("pin readback", pins, rdat);
		bus(1, `IDX_CONVERSION_CONTROL, 4'h8);
		bus(0, `IDX_CONVERSION_CONTROL, 4'h0);
		chk("disabled start", 0, rdat);
		chk("power off", 0, pwr);
		$display("register test done");
		bus(1, `IDX_IRQ_ENABLE, 4'h8);
		for (int i = 0; i < 5; i++) begin
			halt <= i == 2;
			conv(i == 4, i < 4 ? 2'(i) : 2'h0, 2'(i), i[0]);
		end
		$display("conversion test done");
		level <= ~level;
		bus(1, `IDX_CONVERSION_CONTROL, 4'h9);
		// Past the gap, so the abort hits a running conversion
		repeat (60) @(posedge clk);
		bus(1, `IDX_CONVERSION_CONTROL, 4'h1);
		bus(0, `IDX_CONVERSION_CONTROL, 4'h0);
		chk("aborted", 0, rdat[3]);
		chk("no request", 0, irq);
		rdres();
		bus(1, `IDX_CONVERSION_CONTROL, 4'h9);
		stop <= 1;
		repeat (3) @(posedge clk);
		chk("stop power", 0, pwr);
		bus(0, `IDX_CONVERSION_CONTROL, 4'h0);
		chk("stop abort", 0, rdat[3]);
		stop <= 0;
		$display("abort test done");
		summarize();
	end
endmodule
`default_nettype wire
